/* bubble_host_pkg.sv */
// Constants shared by the dual bus host interface of the bubble store.
// Assumes a single 40 MHz clock; all pin timing is counted in its cycles.
// Operation
// - Incremental access runs two 6 us rotations and moves one 16-bit word.
// - Interface logic acts only while the bus power request is low.
// - Access pulses count only while not busy and at least one us long; a pulse on the other bus while busy is kept as waiting.
// - An access pulse wider than 7.5 us selects incremental access.
// - Accepting a pulse latches mode and address and drives busy low.
// - While busy, access pulse, mode and address inputs are ignored; those of the other bus are latched as a waiting request.
// - Word valid high marks good bus data; writer of the data drives it.
// - Write data is captured as the word strobe falls.
// - A rising word strobe says the next word may be placed on the bus.
// - Read data is presented on the bus near the end of the cycle.
// - An access pulse shorter than 7.5 us starts a burst.
// - A stop pulse of at least 1 us inside a strobe low window ends a burst.
// - Burst words are paced by the 166.6 kHz internal drive field.
// - Two identical buses; a request while idle takes sole control.
// - A waiting bus gets 7.5 us priority after busy releases.
// - Incremental rate is any host rate up to the minimum cycle time.
// - Bus control and data pins are active low, apart from word valid, which is active high.
package bubble_host_pkg;

   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned T_GLITCH_NS = 1000;
   localparam int unsigned T_LONG_NS = 7500;
   localparam int unsigned T_STOP_NS = 1000;
   localparam int unsigned T_PRIO_NS = 7500;
   localparam int unsigned T_ROT_NS = 6000;
   localparam int unsigned ROT_PER_WORD = 2;

   // Least times round up, longest times round down
   localparam logic [15:0] GLITCH_CYC =
      16'((T_GLITCH_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] LONG_CYC = 16'((T_LONG_NS * CLK_MHZ) / 1000);
   localparam logic [15:0] STOP_CYC =
      16'((T_STOP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] PRIO_CYC = 16'((T_PRIO_NS * CLK_MHZ) / 1000);
   localparam logic [15:0] ROT_CYC = 16'((T_ROT_NS * CLK_MHZ) / 1000);
   localparam logic [15:0] WORD_CYC = 16'(ROT_PER_WORD * ROT_CYC);
   localparam logic [15:0] HALF_CYC = 16'(ROT_CYC);
   localparam logic [15:0] CNT_MAX = 16'hFFFF;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } seq_state_t;

endpackage

/* bubble_host_port.sv */
// Dual bus user port of the bubble store, with pulse discrimination,
// arbitration, word pacing and two-entry buffers toward the store core.
// Assumes pins arrive asynchronously and the core answers cmd_start.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   // Reset to the idle high level of the pins, so that no false edge or
   // powered bus appears while the stages refill after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '1;
         q <= '1;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
module word_buf2 #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem_q [2];
   logic [1:0] cnt_q;
   logic wp_q;
   logic rp_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rp_q];

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 2'h0;
         wp_q <= 1'b0;
         rp_q <= 1'b0;
      end else begin
         cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
         if (push) wp_q <= ~wp_q;
         if (pop) rp_q <= ~rp_q;
      end
   end

   always_ff @(posedge clk) begin
      if (push) mem_q[wp_q] <= in_data;
   end
endmodule

////////////////////////////////////////////////////////////////////////////
module bubble_host_port
   import bubble_host_pkg::*;
#(
   parameter int WORD_W = 16,
   parameter int ADDR_W = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus pins, index is the bus number, active low apart from word valid
   input wire logic [1:0] pwr_req_n,
   input wire logic [1:0] access_n,
   input wire logic [1:0] write_n,
   input wire logic [1:0][ADDR_W-1:0] cell_sel_n,
   output logic [1:0] busy_n,
   output logic [1:0] word_strobe_n,
   input wire logic [1:0] valid_i,
   output logic [1:0] valid_o,
   output logic [1:0] valid_oe,
   input wire logic [1:0][WORD_W-1:0] data_i,
   output logic [1:0][WORD_W-1:0] data_o,
   output logic [1:0] data_oe,
   // Command toward the store core
   output logic cmd_start,
   output logic cmd_done,
   output logic cmd_write,
   output logic cmd_burst,
   output logic cmd_bus,
   output logic [ADDR_W-1:0] cmd_addr,
   // Read words from the core
   input wire logic rd_valid,
   output logic rd_ready,
   input wire logic [WORD_W-1:0] rd_data,
   // Write words to the core
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [WORD_W-1:0] wr_data
);

   if (WORD_W < 1 || ADDR_W < 1 || ADDR_W > 8) begin : g_chk
      $error("bubble_host_port: unsupported width");
   end

   localparam int SW = 3 + ADDR_W + WORD_W + 1;

   logic [1:0] pwr_on;
   logic [1:0] acc_low;
   logic [1:0] wr_s;
   logic [ADDR_W-1:0] addr_s [2];
   logic [WORD_W-1:0] data_s [2];
   logic [1:0] valid_s;
   logic [15:0] low_cnt_q [2];
   logic [1:0] acc_prev_q;
   logic [1:0] blk_q;
   logic [1:0] req_ev;

   seq_state_t state_q;
   logic busy;
   logic [15:0] phase_q;
   logic strobe_low_q;
   logic owner_q;
   logic burst_q;
   logic wr_q;
   logic stop_q;
   logic [ADDR_W-1:0] addr_q;
   logic [1:0] pend_q;
   logic pend_long_q [2];
   logic pend_wr_q [2];
   logic [ADDR_W-1:0] pend_addr_q [2];
   logic prio_on_q;
   logic prio_bus_q;
   logic [15:0] prio_cnt_q;
   logic rr_q;
   logic grant;
   logic gbus;
   logic step;
   logic fall_ev;
   logic wrap_ev;
   logic end_ev;
   logic [WORD_W-1:0] dout_q;
   logic dout_vld_q;
   logic wb_in_ready;
   logic rb_out_valid;
   logic [WORD_W-1:0] rb_out_data;

   assign busy = (state_q == ST_RUN);

   ////////////////////////////////////////////////////////////////////////
   // Per bus pin capture and pulse width measurement
   for (genvar b = 0; b < 2; b++) begin : g_bus
      logic [SW-1:0] raw;
      logic [SW-1:0] syn;
      assign raw = {pwr_req_n[b], access_n[b], write_n[b], cell_sel_n[b],
                    data_i[b], valid_i[b]};
      pin_sync #(.W(SW)) u_sync (
         .clk(clk),
         .rst(rst),
         .d(raw),
         .q(syn)
      );
      // Synchroniser resets high, so a bus reads as off until its
      // request line is really seen low
      assign pwr_on[b] = ~syn[SW-1] && ~rst;
      assign acc_low[b] = ~syn[SW-2] && pwr_on[b];
      assign wr_s[b] = ~syn[SW-3];
      assign addr_s[b] = ~syn[WORD_W+ADDR_W:WORD_W+1];
      assign data_s[b] = ~syn[WORD_W:1];
      assign valid_s[b] = syn[0];

      // Saturating low time counter on the crystal timebase
      always_ff @(posedge clk) begin
         if (rst || !acc_low[b]) begin
            low_cnt_q[b] <= 16'h0000;
         end else if (low_cnt_q[b] != CNT_MAX) begin
            low_cnt_q[b] <= 16'(low_cnt_q[b] + 16'h0001);
         end
      end

      always_ff @(posedge clk) begin
         if (rst) acc_prev_q[b] <= 1'b0;
         else acc_prev_q[b] <= acc_low[b];
      end

      // A low that overlaps our own cycle is a stop pulse, never a request
      always_ff @(posedge clk) begin
         if (rst) blk_q[b] <= 1'b0;
         else if (busy && owner_q == b) blk_q[b] <= 1'b1;
         else if (!acc_low[b]) blk_q[b] <= 1'b0;
      end

      assign req_ev[b] = acc_prev_q[b] && !acc_low[b] && pwr_on[b] &&
                         low_cnt_q[b] >= GLITCH_CYC && !blk_q[b] &&
                         !(busy && owner_q == b);

      assign busy_n[b] = ~(busy && pwr_on[b]);
      assign word_strobe_n[b] = ~(strobe_low_q && owner_q == b &&
                                  pwr_on[b]);
      assign data_oe[b] = busy && !wr_q && owner_q == b && pwr_on[b];
      assign valid_oe[b] = data_oe[b];
      assign valid_o[b] = dout_vld_q;
      assign data_o[b] = ~dout_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending requests; a new pulse wins over the clearing grant
   always_ff @(posedge clk) begin
      if (rst) begin
         pend_q <= 2'b00;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (req_ev[b]) pend_q[b] <= 1'b1;
            else if (grant && gbus == b) pend_q[b] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int b = 0; b < 2; b++) begin
         if (req_ev[b]) begin
            pend_long_q[b] <= (low_cnt_q[b] > LONG_CYC);
            pend_wr_q[b] <= wr_s[b];
            pend_addr_q[b] <= addr_s[b];
         end
      end
   end

   // Idle grant: a lone request takes the module, a tie goes to the
   // priority holder, else alternates between the buses
   always_comb begin
      grant = 1'b0;
      gbus = 1'b0;
      if (state_q == ST_IDLE && pend_q != 2'b00) begin
         grant = 1'b1;
         if (pend_q == 2'b11) gbus = prio_on_q ? prio_bus_q : rr_q;
         else gbus = pend_q[1];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) rr_q <= 1'b0;
      else if (grant) rr_q <= ~gbus;
   end

   always_ff @(posedge clk) begin
      if (rst || grant) begin
         prio_on_q <= 1'b0;
         prio_bus_q <= 1'b0;
         prio_cnt_q <= 16'h0000;
      end else if (end_ev && pend_q[~owner_q]) begin
         prio_on_q <= 1'b1;
         prio_bus_q <= ~owner_q;
         prio_cnt_q <= PRIO_CYC;
      end else if (prio_cnt_q != 16'h0000) begin
         prio_cnt_q <= 16'(prio_cnt_q - 16'h0001);
      end else begin
         prio_on_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Word sequencer: one word per two field rotations
   // The strobe fall is held off while the buffer cannot take or give a
   // word, so a slow core stretches the cycle instead of losing data
   assign step = !(phase_q == 16'(HALF_CYC - 16'h0001) &&
                   (wr_q ? !wb_in_ready : !rb_out_valid));
   assign fall_ev = busy && step && phase_q == 16'(HALF_CYC - 16'h0001);
   assign wrap_ev = busy && step && phase_q == 16'(WORD_CYC - 16'h0001);
   assign end_ev = wrap_ev && (!burst_q || stop_q);

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         phase_q <= 16'h0000;
         owner_q <= 1'b0;
         burst_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (grant) begin
                  state_q <= ST_RUN;
                  phase_q <= 16'h0000;
                  owner_q <= gbus;
                  burst_q <= !pend_long_q[gbus];
                  wr_q <= pend_wr_q[gbus];
                  addr_q <= pend_addr_q[gbus];
               end
            end
            ST_RUN: begin
               if (wrap_ev) begin
                  phase_q <= 16'h0000;
                  if (end_ev) state_q <= ST_IDLE;
               end else if (step) begin
                  phase_q <= 16'(phase_q + 16'h0001);
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !busy || wrap_ev) strobe_low_q <= 1'b0;
      else if (fall_ev) strobe_low_q <= 1'b1;
   end

   always_ff @(posedge clk) begin
      if (rst || grant) stop_q <= 1'b0;
      else if (busy && burst_q && strobe_low_q &&
               low_cnt_q[owner_q] >= STOP_CYC) stop_q <= 1'b1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_start <= 1'b0;
         cmd_done <= 1'b0;
         cmd_write <= 1'b0;
         cmd_burst <= 1'b0;
         cmd_bus <= 1'b0;
         cmd_addr <= '0;
      end else begin
         cmd_start <= grant;
         cmd_done <= end_ev;
         if (grant) begin
            cmd_write <= pend_wr_q[gbus];
            cmd_burst <= !pend_long_q[gbus];
            cmd_bus <= gbus;
            cmd_addr <= pend_addr_q[gbus];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data path buffers
   word_buf2 #(.W(WORD_W)) u_wbuf (
      .clk(clk),
      .rst(rst),
      .in_valid(fall_ev && wr_q && valid_s[owner_q]),
      .in_ready(wb_in_ready),
      .in_data(data_s[owner_q]),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(wr_data)
   );

   word_buf2 #(.W(WORD_W)) u_rbuf (
      .clk(clk),
      .rst(rst),
      .in_valid(rd_valid),
      .in_ready(rd_ready),
      .in_data(rd_data),
      .out_valid(rb_out_valid),
      .out_ready(fall_ev && !wr_q),
      .out_data(rb_out_data)
   );

   // Read word shown in the second half of the cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         dout_q <= '0;
         dout_vld_q <= 1'b0;
      end else if (fall_ev && !wr_q) begin
         dout_q <= rb_out_data;
         dout_vld_q <= 1'b1;
      end else if (wrap_ev || !busy) begin
         dout_vld_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic [15:0] low_len_q;
   logic [7:0] words_q;
   always_ff @(posedge clk) begin
      if (rst || !strobe_low_q) low_len_q <= 16'h0000;
      else low_len_q <= 16'(low_len_q + 16'h0001);
   end
   always_ff @(posedge clk) begin
      if (rst || grant) words_q <= 8'h00;
      else if (fall_ev) words_q <= 8'(words_q + 8'h01);
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_grant_latches: assert property (grant |=> busy &&
      addr_q == $past(pend_addr_q[gbus]) && owner_q == $past(gbus))
      else $error("grant did not latch address or raise busy");
   a_mode_select: assert property (grant |=>
      burst_q == cmd_burst && burst_q == !$past(pend_long_q[gbus]))
      else $error("access mode does not follow pulse width");
   a_short_reject: assert property (acc_prev_q[0] && !acc_low[0] &&
      low_cnt_q[0] < GLITCH_CYC && !pend_q[0] |=> !pend_q[0])
      else $error("glitch accepted as request");
   a_owner_ignored: assert property (busy && $past(busy) |->
      $stable(addr_q) && $stable(cmd_addr) && !req_ev[owner_q])
      else $error("owner inputs taken while busy");
   a_incr_one_word: assert property ($fell(busy) && !burst_q |->
      words_q == 8'h01)
      else $error("incremental cycle moved other than one word");
   a_window_len: assert property ($fell(strobe_low_q) && busy |->
      $past(low_len_q) == 16'(WORD_CYC - HALF_CYC - 16'h0001))
      else $error("strobe low window has wrong length");
   // A waiting bus may take the module one cycle after the stop
   a_stop_ends: assert property (wrap_ev && stop_q |=> !busy ##1
      (!busy || owner_q != $past(owner_q, 2)))
      else $error("burst ran on after stop pulse");
   a_read_late: assert property (valid_oe[0] && valid_o[0] |->
      strobe_low_q)
      else $error("read data shown outside second half");
   a_unpowered_quiet: assert property (!pwr_on[1] |-> busy_n[1] &&
      word_strobe_n[1] && !data_oe[1])
      else $error("unpowered bus is driven");
   a_prio_taken: assert property (end_ev && pend_q[~owner_q] |=>
      ##[0:2] (owner_q == $past(~owner_q, 2) || grant))
      else $error("waiting bus lost priority");

   c_incr: cover property ($fell(busy) && !burst_q);
   c_burst4: cover property ($fell(busy) && burst_q && words_q == 8'h04);
   c_both_pend: cover property (grant && pend_q == 2'b11);
   c_stall: cover property (busy && !step);

endmodule

`default_nettype wire

/* bus_host_model.sv */
// Behavioural user controller for one bus of the bubble store port.
// Assumes a 40 MHz clk; pins change only just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module bus_host_model (
   // Clock
   input wire logic clk,
   // Bus pins, active low apart from word valid
   output logic pwr_req_n,
   output logic access_n,
   output logic write_n,
   output logic [2:0] cell_sel_n,
   output logic valid_i,
   output logic [15:0] data_i
);
   initial begin
      pwr_req_n = 1'b1;
      access_n = 1'b1;
      write_n = 1'b1;
      cell_sel_n = 3'h7;
      valid_i = 1'b0;
      data_i = 16'hFFFF;
   end

   // Power may be dropped between cycles to save standby power
   task automatic power(input logic on);
      @(posedge clk);
      pwr_req_n <= ~on;
      if (on) begin
         repeat (80) @(posedge clk);
      end
   endtask

   // Mode and address ride with the pulse; width picks the access kind
   task automatic pulse(input int w, input logic wr, input logic [2:0] a);
      @(posedge clk);
      write_n <= ~wr;
      cell_sel_n <= ~a;
      access_n <= 1'b0;
      repeat (w) @(posedge clk);
      access_n <= 1'b1;
   endtask

   task automatic put_word(input logic [15:0] w);
      @(posedge clk);
      data_i <= ~w;
      valid_i <= 1'b1;
   endtask

   // A released bus shows the inverse, so a stale word never matches
   task automatic drop_word();
      @(posedge clk);
      data_i <= ~data_i;
      valid_i <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* bubble_memory_host_interface_tb_top.sv */
// Self-checking bench for the dual bus port of the bubble store.
// Assumes bus_host_model on each bus; the core side is modelled here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   compares++; \
   if ((g) !== (e)) begin \
      err_total++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
   end \
end

////////////////////////////////////////////////////////////////////////////
module bubble_memory_host_interface_tb_top;
   import bubble_host_pkg::*;
   localparam int LIMIT = 20000;
   logic clk;
   logic rst;
   wire [1:0] pwr_n, acc_n, wr_n, vld_i;
   wire [2:0] sel0, sel1;
   wire [15:0] d0, d1;
   logic [1:0] busy_n, word_strobe_n, valid_o, valid_oe, data_oe;
   logic [1:0][15:0] data_o;
   logic cmd_start, cmd_done, cmd_write, cmd_burst, cmd_bus;
   logic [2:0] cmd_addr;
   logic rd_valid, rd_ready, wr_valid, wr_ready;
   logic [15:0] rd_data, wr_data;
   int err_total, compares, cyc, n_start, n_done, n_fall, gap, last_fall;
   int blen, last_blen;
   logic s_bus, s_write, s_burst, stb_q;
   logic [2:0] s_addr;
   logic [15:0] rd_q[$];
   logic [15:0] wr_seen[$];

   bus_host_model host0 (.clk(clk), .pwr_req_n(pwr_n[0]),
      .access_n(acc_n[0]), .write_n(wr_n[0]), .cell_sel_n(sel0),
      .valid_i(vld_i[0]), .data_i(d0));
   bus_host_model host1 (.clk(clk), .pwr_req_n(pwr_n[1]),
      .access_n(acc_n[1]), .write_n(wr_n[1]), .cell_sel_n(sel1),
      .valid_i(vld_i[1]), .data_i(d1));
   bubble_host_port dut (.clk(clk), .rst(rst), .pwr_req_n(pwr_n),
      .access_n(acc_n), .write_n(wr_n), .cell_sel_n({sel1, sel0}),
      .busy_n(busy_n), .word_strobe_n(word_strobe_n), .valid_i(vld_i),
      .valid_o(valid_o), .valid_oe(valid_oe), .data_i({d1, d0}),
      .data_o(data_o), .data_oe(data_oe), .cmd_start(cmd_start),
      .cmd_done(cmd_done), .cmd_write(cmd_write), .cmd_burst(cmd_burst),
      .cmd_bus(cmd_bus), .cmd_addr(cmd_addr), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_data(wr_data));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Core model and event monitor
   always @(posedge clk) begin
      cyc++;
      if (cmd_start === 1'b1) begin
         n_start++;
         s_bus = cmd_bus;
         s_write = cmd_write;
         s_burst = cmd_burst;
         s_addr = cmd_addr;
      end
      if (cmd_done === 1'b1) n_done++;
      if (wr_valid === 1'b1 && wr_ready === 1'b1) wr_seen.push_back(wr_data);
      if (rd_valid && rd_ready === 1'b1) void'(rd_q.pop_front());
      rd_valid <= (rd_q.size() != 0);
      rd_data <= (rd_q.size() != 0) ? rd_q[0] : ~rd_data;
      if (stb_q && !(&word_strobe_n)) begin
         gap = cyc - last_fall;
         last_fall = cyc;
         n_fall++;
      end
      stb_q = &word_strobe_n;
      if (&busy_n) begin
         if (blen != 0) last_blen = blen;
         blen = 0;
      end else begin
         blen++;
      end
      if (cyc == LIMIT) begin
         err_total++;
         $display("[FAIL] run time expected end seen hang");
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   function automatic logic cond(input int k, input int b);
      case (k)
         0: return busy_n[b] === 1'b0;
         1: return busy_n[b] === 1'b1;
         2: return word_strobe_n[b] === 1'b0;
         default: return word_strobe_n[b] === 1'b1;
      endcase
   endfunction

   task automatic wait_for(input int k, input int b, input int lim);
      int n;
      n = 0;
      while (!cond(k, b) && n < lim) begin
         tick(1);
         n++;
      end
      `CHK("wait event", 1'b1, cond(k, b))
   endtask

   task automatic hpulse(input int b, input int w, input logic wr,
                         input logic [2:0] a);
      if (b == 1) host1.pulse(w, wr, a);
      else host0.pulse(w, wr, a);
   endtask

   function automatic logic [15:0] seen(input int i);
      return (i < wr_seen.size()) ? wr_seen[i] : 16'hXXXX;
   endfunction

   task automatic set_wr_ready(input logic v);
      @(posedge clk);
      wr_ready <= v;
      #1;
   endtask

   task automatic end_test(input string nm);
      $display("test %s finished, mismatches so far %0d", nm, err_total);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_inc_read(input int b, input logic [2:0] a,
                             input logic [15:0] w);
      int ns, nd;
      ns = n_start;
      nd = n_done;
      rd_q.push_back(w);
      hpulse(b, 320, 1'b0, a);
      wait_for(0, b, 20);
      tick(2);
      `CHK("starts", ns + 1, n_start)
      `CHK("cmd_bus", b[0], s_bus)
      `CHK("cmd_write", 1'b0, s_write)
      `CHK("cmd_burst", 1'b0, s_burst)
      `CHK("cmd_addr", a, s_addr)
      wait_for(2, b, 600);
      `CHK("data_o", ~w, data_o[b])
      `CHK("valid_o", 1'b1, valid_o[b])
      `CHK("oe", 2'b11, {valid_oe[b], data_oe[b]})
      `CHK("idle bus oe", 1'b0, data_oe[1-b])
      wait_for(1, b, 600);
      tick(2);
      `CHK("busy cycles", 480, last_blen)
      `CHK("dones", nd + 1, n_done)
      `CHK("read words left", 0, rd_q.size())
      end_test("incremental read");
   endtask

   task automatic t_inc_write();
      wr_seen.delete();
      host1.put_word(16'h3C96);
      hpulse(1, 320, 1'b1, 3'h2);
      wait_for(0, 1, 20);
      tick(2);
      `CHK("cmd_write", 1'b1, s_write)
      `CHK("cmd_bus", 1'b1, s_bus)
      `CHK("write oe", 2'b00, data_oe)
      wait_for(2, 1, 600);
      tick(4);
      host1.drop_word();
      wait_for(1, 1, 600);
      tick(4);
      `CHK("written", 16'h3C96, seen(0))
      `CHK("write count", 1, wr_seen.size())
      end_test("incremental write");
   endtask

   task automatic t_dual();
      int ns;
      ns = n_start;
      rd_q.push_back(16'hC0DE);
      rd_q.push_back(16'h5A5A);
      hpulse(0, 320, 1'b0, 3'h3);
      wait_for(0, 0, 20);
      `CHK("busy on both", 2'b00, busy_n)
      hpulse(0, 100, 1'b1, 3'h6);
      hpulse(1, 320, 1'b0, 3'h5);
      `CHK("ignored pulse", ns + 1, n_start)
      `CHK("held addr", 3'h3, cmd_addr)
      `CHK("held mode", 1'b0, cmd_write)
      wait_for(1, 0, 300);
      wait_for(0, 1, 20);
      tick(2);
      `CHK("waiting served", ns + 2, n_start)
      `CHK("waiting bus", 1'b1, s_bus)
      `CHK("waiting addr", 3'h5, s_addr)
      `CHK("waiting kind", 1'b0, s_burst)
      wait_for(1, 1, 600);
      tick(2);
      `CHK("read words left", 0, rd_q.size())
      end_test("dual bus");
   endtask

   // Core stalls until the write buffer refuses, then drains it
   task automatic t_burst_write();
      int f0;
      f0 = n_fall;
      wr_seen.delete();
      set_wr_ready(1'b0);
      host0.put_word(16'h1357);
      hpulse(0, 100, 1'b1, 3'h7);
      wait_for(0, 0, 20);
      tick(2);
      `CHK("burst kind", 1'b1, s_burst)
      wait_for(2, 0, 600);
      wait_for(3, 0, 300);
      host0.put_word(16'h2468);
      wait_for(2, 0, 300);
      tick(1);
      `CHK("word spacing", 480, gap)
      wait_for(3, 0, 300);
      host0.put_word(16'hBEEF);
      tick(600);
      `CHK("stalled strobe", 1'b1, word_strobe_n[0])
      `CHK("stalled core", 0, wr_seen.size())
      set_wr_ready(1'b1);
      wait_for(2, 0, 300);
      tick(5);
      hpulse(0, 60, 1'b1, 3'h7);
      wait_for(1, 0, 300);
      tick(4);
      `CHK("windows", 3, n_fall - f0)
      `CHK("word 0", 16'h1357, seen(0))
      `CHK("word 1", 16'h2468, seen(1))
      `CHK("word 2", 16'hBEEF, seen(2))
      `CHK("drained", 1'b0, wr_valid)
      host0.drop_word();
      end_test("burst write");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      rd_valid = 1'b0;
      rd_data = 16'h0000;
      wr_ready = 1'b1;
      stb_q = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK("reset busy", 2'b11, busy_n)
      `CHK("reset strobe", 2'b11, word_strobe_n)
      `CHK("reset oe", 4'h0, {valid_oe, data_oe})
      @(posedge clk);
      rst <= 1'b0;
      tick(6);
      hpulse(0, 320, 1'b0, 3'h1);
      tick(20);
      `CHK("unpowered busy", 2'b11, busy_n)
      `CHK("unpowered start", 0, n_start)
      end_test("unpowered");
      fork
         host0.power(1'b1);
         host1.power(1'b1);
      join
      hpulse(0, 38, 1'b0, 3'h1);
      tick(20);
      `CHK("glitch start", 0, n_start)
      `CHK("glitch busy", 2'b11, busy_n)
      end_test("glitch");
      t_inc_read(0, 3'h5, 16'hA5C3);
      t_inc_read(0, 3'h0, 16'h0FF0);
      t_inc_write();
      t_dual();
      t_burst_write();
      host0.power(1'b0);
      tick(6);
      `CHK("released bus", 1'b1, busy_n[0])
      tally_and_finish();
   end
endmodule
`default_nettype wire
